// ===== shared/dss_if.sv
// Wires of the serial link between codec and processor
`timescale 1ns/100ps
`default_nettype none
interface dss_if;
   logic serial_bit_clock;
   logic serial_tx_data;
   logic transmit_frame_sync;
   logic serial_rx_data;
   logic receive_frame_sync;
   logic processor_interrupt_out;
   modport device (
      output serial_bit_clock, serial_tx_data, transmit_frame_sync,
      output processor_interrupt_out,
      input serial_rx_data, receive_frame_sync
   );
   modport processor (
      input serial_bit_clock, serial_tx_data, transmit_frame_sync,
      input processor_interrupt_out,
      output serial_rx_data, receive_frame_sync
   );
endinterface
`default_nettype wire

// ===== shared/dss_pkg.sv
// Types shared by both ends of the statistics serial link
package dss_pkg;
   typedef enum logic [1:0] {dss_idle, dss_sync, dss_data} dss_tx_state_type;
   typedef logic [15:0] dss_word_type;
endpackage

// ===== shared/dss_regs.svh
// Constants of the statistics serial link shared by both ends
`ifndef DSS_REGS_SVH
`define DSS_REGS_SVH
`define DSS_WORD_BITS 16
`define DSS_TX_SLOTS 52
`define DSS_RX_SLOTS 84
`define DSS_DIV_LAST 2'h3
`define DSS_PH_RISE 2'h0
`define DSS_PH_FALL 2'h2
`define DSS_PH_SAMPLE 2'h3
`define DSS_BIT_LAST 4'hf
`endif

// ===== sim/dss_link_sva.sv
// Concurrent checks on the link wires between the two ends
`timescale 1ns/100ps
`default_nettype none
module dss_link_sva (
   input wire logic clk, // Device clock
   input wire logic nrst, // Sync reset, active low
   input wire logic serial_bit_clock, // Bit clock
   input wire logic serial_tx_data, // Device data
   input wire logic transmit_frame_sync, // Device sync
   input wire logic serial_rx_data, // Processor data
   input wire logic receive_frame_sync, // Processor sync
   input wire logic processor_interrupt_out // Interrupt line
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Bit clock rises since the last sync; saturates so the first frame passes
   logic [11:0] gap;
   logic [3:0] up;
   logic sbc_q;
   logic tfs_q;
   wire sbc_rise = serial_bit_clock & ~sbc_q;
   wire tfs_rise = transmit_frame_sync & ~tfs_q;
   wire [11:0] next_gap = tfs_rise ? 12'h000 : (sbc_rise & ~&gap) ? gap + 12'h001 : gap;
   // Clock shape is only judged once the divider has settled after reset
   wire [3:0] next_up = up[3] ? up : up + 4'h1;
   always_ff @(posedge clk) begin
      sbc_q <= serial_bit_clock;
      tfs_q <= transmit_frame_sync;
      gap <= nrst ? next_gap : 12'hfff;
      up <= nrst ? next_up : 4'h0;
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_clk_high_two: assert property (up[3] && $rose(serial_bit_clock) |=> serial_bit_clock ##1 !serial_bit_clock)
      else $error("bit clock high time wrong");
   a_clk_low_two: assert property (up[3] && $fell(serial_bit_clock) |=> !serial_bit_clock ##1 serial_bit_clock)
      else $error("bit clock low time wrong");
   a_data_after_rise: assert property ($changed(serial_tx_data) |-> serial_bit_clock &&
      $past(serial_bit_clock) && !$past(serial_bit_clock, 2))
      else $error("data moved away from launch point");
   a_sync_after_rise: assert property ($changed(transmit_frame_sync) |-> serial_bit_clock &&
      $past(serial_bit_clock) && !$past(serial_bit_clock, 2))
      else $error("sync moved away from launch point");
   a_sync_one_period: assert property ($rose(transmit_frame_sync) |-> transmit_frame_sync[*4] ##1 !transmit_frame_sync)
      else $error("sync pulse not one period");
   a_sync_low_min: assert property ($fell(transmit_frame_sync) |-> !transmit_frame_sync[*4])
      else $error("sync low too short");
   a_frame_slot_count: assert property ($rose(transmit_frame_sync) |-> gap >= 12'h340)
      else $error("new frame before all slots sent");
   a_irq_with_sync: assert property (transmit_frame_sync |-> processor_interrupt_out)
      else $error("interrupt low during sync");
   a_irq_over_bits: assert property ($fell(transmit_frame_sync) |-> processor_interrupt_out[*8])
      else $error("interrupt dropped in frame");
   a_rx_sync_min: assert property ($rose(receive_frame_sync) |-> receive_frame_sync[*3])
      else $error("receive sync too short");
   cover property ($rose(transmit_frame_sync));
   cover property (receive_frame_sync ##[4:8] serial_rx_data);
   cover property ($fell(processor_interrupt_out));
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Bench joining device and processor ends over the serial link
`timescale 1ns/100ps
`default_nettype none
module testbench;
   // ----------------------------------------
   // Stimulus and wiring
   // ----------------------------------------
   typedef struct {
      dss_pkg::dss_word_type tb;
      dss_pkg::dss_word_type bb;
      int ns;
      int nb;
   } dss_row_type;
   dss_row_type rows [3] = '{'{16'h8001, 16'h7ffe, 52, 84}, '{16'h5a5a, 16'ha5a5, 52, 84},
      '{16'hffff, 16'h0000, 52, 84}};
   logic clk = 1'b0;
   logic pclk = 1'b0;
   logic nrst = 1'b0;
   logic processor_present = 1'b1;
   logic stats_start = 1'b0;
   logic bw_start = 1'b0;
   logic stats_take, bw_take, stats_valid, bin_width_valid, irq_edge;
   dss_pkg::dss_word_type st_in = 16'h0000;
   dss_pkg::dss_word_type bw_in = 16'h0000;
   dss_pkg::dss_word_type st_got, bw_got, tx_base, bw_base, wt, wr;
   int n_fail = 0;
   int samples_checked = 0;
   int tx_n, bw_n, s_cnt, b_cnt, irq_cnt;
   initial begin
      forever #5 clk = ~clk;
   end
   // Processor clock well above the bit rate so its edge detector keeps up
   initial begin
      forever #2.1 pclk = ~pclk;
   end
   dss_if link_if ();
   dss_device dss_device_i (.clk(clk), .nrst(nrst), .processor_present(processor_present),
      .stats_start(stats_start), .stats_word(st_in), .stats_take(stats_take),
      .quantizer_bin_width(bw_got), .bin_width_valid(bin_width_valid), .link(link_if.device));
   dss_processor dss_processor_i (.clk(pclk), .nrst(nrst), .bw_start(bw_start), .bw_word(bw_in),
      .bw_take(bw_take), .stats_word(st_got), .stats_valid(stats_valid), .irq_edge(irq_edge),
      .link(link_if.processor));
   dss_link_sva dss_link_sva_i (.clk(clk), .nrst(nrst),
      .serial_bit_clock(link_if.serial_bit_clock), .serial_tx_data(link_if.serial_tx_data),
      .transmit_frame_sync(link_if.transmit_frame_sync), .serial_rx_data(link_if.serial_rx_data),
      .receive_frame_sync(link_if.receive_frame_sync),
      .processor_interrupt_out(link_if.processor_interrupt_out));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic dss_pkg::dss_word_type pat(input dss_pkg::dss_word_type b, input int n);
      return b ^ {n[7:0], ~n[7:0]};
   endfunction
   task automatic check(input dss_pkg::dss_word_type got, input dss_pkg::dss_word_type exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      if (stats_take) begin
         st_in <= pat(tx_base, tx_n + 1);
         tx_n <= tx_n + 1;
      end
      if (bin_width_valid) begin
         check(bw_got, pat(bw_base, b_cnt));
         b_cnt <= b_cnt + 1;
      end
   end
   always @(posedge pclk) begin
      if (bw_take) begin
         bw_in <= pat(bw_base, bw_n + 1);
         bw_n <= bw_n + 1;
      end
      if (stats_valid) begin
         check(st_got, pat(tx_base, s_cnt));
         s_cnt <= s_cnt + 1;
      end
      if (irq_edge) begin
         irq_cnt <= irq_cnt + 1;
      end
   end
   // Reads the first word of a frame straight off the wire at bit clock falls
   task automatic grab(input bit rx, output dss_pkg::dss_word_type w);
      int k;
      int bits;
      logic prev;
      k = 0;
      bits = -1;
      prev = 1'b0;
      w = 16'h0000;
      while (bits < 16 && k < 4000) begin
         @(negedge clk);
         if (prev && !link_if.serial_bit_clock) begin
            if (bits >= 0) begin
               w = {w[14:0], rx ? link_if.serial_rx_data : link_if.serial_tx_data};
               bits++;
            end else if (rx ? link_if.receive_frame_sync : link_if.transmit_frame_sync) begin
               bits = 0;
            end
         end
         prev = link_if.serial_bit_clock;
         k++;
      end
      if (bits < 16) begin
         n_fail++;
         tally_and_finish;
      end
   endtask
   task automatic start_frames(input dss_pkg::dss_word_type tb, input dss_pkg::dss_word_type bb,
         input bit both);
      tx_base = tb;
      bw_base = bb;
      tx_n = 0;
      bw_n = 0;
      s_cnt = 0;
      b_cnt = 0;
      irq_cnt = 0;
      @(posedge clk);
      st_in <= pat(tb, 0);
      stats_start <= 1'b1;
      @(posedge clk);
      stats_start <= 1'b0;
      if (both) begin
         @(posedge pclk);
         bw_in <= pat(bb, 0);
         bw_start <= 1'b1;
         @(posedge pclk);
         bw_start <= 1'b0;
      end
   endtask
   task automatic wait_counts(input int ns, input int nb);
      int k;
      k = 0;
      while ((s_cnt < ns || b_cnt < nb) && k < 20000) begin
         @(posedge clk);
         k++;
      end
      if (s_cnt < ns || b_cnt < nb) begin
         n_fail++;
         tally_and_finish;
      end
      // Extra words after the expected count would show here
      repeat (300) @(posedge clk);
      check(16'(s_cnt), 16'(ns));
      check(16'(b_cnt), 16'(nb));
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         fork
            grab(1'b0, wt);
            grab(1'b1, wr);
            start_frames(rows[i].tb, rows[i].bb, 1'b1);
         join
         check(wt, pat(rows[i].tb, 0));
         check(wr, pat(rows[i].bb, 0));
         wait_counts(rows[i].ns, rows[i].nb);
         check(16'(irq_cnt), 16'h0001);
      end
      // Second request while the first frame is still on the wire is refused
      start_frames(16'h1234, 16'h0000, 1'b0);
      repeat (100) @(posedge clk);
      stats_start <= 1'b1;
      @(posedge clk);
      stats_start <= 1'b0;
      wait_counts(52, 0);
      processor_present <= 1'b0;
      start_frames(16'h4321, 16'h1111, 1'b1);
      repeat (2000) @(posedge clk);
      check(16'(s_cnt + b_cnt), 16'h0000);
      check({15'h0000, link_if.processor_interrupt_out}, 16'h0000);
      processor_present <= 1'b1;
      start_frames(16'h0f0f, 16'hf0f0, 1'b1);
      repeat (500) @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check({12'h000, link_if.serial_bit_clock, link_if.transmit_frame_sync,
         link_if.serial_tx_data, link_if.processor_interrupt_out}, 16'h0000);
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      start_frames(16'hc3c3, 16'h3c3c, 1'b1);
      wait_counts(52, 84);
      tally_and_finish;
   end
endmodule
`default_nettype wire

// ===== src/dss_device.sv
// Codec end: makes the bit clock, sends statistics, receives bin widths
`timescale 1ns/100ps
`default_nettype none
`include "dss_regs.svh"
module dss_device (
   input wire logic clk, // Video pixel clock
   input wire logic nrst, // Synchronous reset, active low
   input wire logic processor_present, // Setup bit: external processor fitted
   input wire logic stats_start, // Pulse: send a statistics frame
   input wire dss_pkg::dss_word_type stats_word, // Statistics word for current slot
   output logic stats_take, // Pulse: stats_word consumed
   output dss_pkg::dss_word_type quantizer_bin_width, // Last bin width received
   output logic bin_width_valid, // Pulse: new bin width
   dss_if.device link // Serial link
);
   // ------------------------------------------------------------
   // Bit clock divider
   // ------------------------------------------------------------
   logic [1:0] phase;
   logic bit_clock;
   logic pending;
   logic rx_sync_meta, rx_sync_sync, rx_data_meta, rx_data_sync;
   logic tx_busy, rx_busy, tx_sync, tx_data, take, in_valid;
   dss_pkg::dss_word_type in_word;
   logic irq;

   // Launch one cycle after the rise keeps data away from the partner's edge
   wire logic launch = (phase == `DSS_PH_RISE);
   // Two synchroniser flops lag the pins by two clocks, so reading one phase after the
   // fall takes the wire as it stood at the fall, well clear of the partner's launch
   wire logic sample = (phase == `DSS_PH_SAMPLE);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         phase <= 2'h0;
         bit_clock <= 1'b0;
      end else begin
         phase <= phase + 2'h1; // Divide by four
         bit_clock <= (phase == `DSS_DIV_LAST) || (phase == `DSS_PH_RISE);
      end
   end

   // Partner inputs cross in through two flops
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rx_sync_meta <= 1'b0;
         rx_sync_sync <= 1'b0;
         rx_data_meta <= 1'b0;
         rx_data_sync <= 1'b0;
      end else begin
         rx_sync_meta <= link.receive_frame_sync;
         rx_sync_sync <= rx_sync_meta;
         rx_data_meta <= link.serial_rx_data;
         rx_data_sync <= rx_data_meta;
      end
   end

   // ------------------------------------------------------------
   // Frame engine
   // ------------------------------------------------------------
   // Start request is held until the next launch phase picks it up
   // A request on a launch cycle wins over the clear, so no pulse is lost
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pending <= 1'b0;
      end else if (stats_start && processor_present) begin
         pending <= 1'b1; // Nothing is sent without a processor
      end else if (launch) begin
         pending <= 1'b0;
      end
   end

   dss_shifter #(.SLOTS_OUT(`DSS_TX_SLOTS), .SLOTS_IN(`DSS_RX_SLOTS)) u_shift (
      .clk(clk),
      .nrst(nrst),
      .launch(launch),
      .sample(sample),
      .start(pending),
      .out_word(stats_word),
      .out_take(take),
      .out_busy(tx_busy),
      .sync_out(tx_sync),
      .data_out(tx_data),
      .sync_in(rx_sync_sync && processor_present),
      .data_in(rx_data_sync),
      .in_word(in_word),
      .in_valid(in_valid),
      .in_busy(rx_busy)
   );

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq <= 1'b0;
         stats_take <= 1'b0;
         quantizer_bin_width <= 16'h0000;
         bin_width_valid <= 1'b0;
      end else begin
         irq <= tx_busy || pending || rx_busy; // Held through both frames
         stats_take <= take;
         bin_width_valid <= in_valid;
         if (in_valid) begin
            quantizer_bin_width <= in_word;
         end
      end
   end

   assign link.serial_bit_clock = bit_clock;
   assign link.transmit_frame_sync = tx_sync;
   assign link.serial_tx_data = tx_data;
   assign link.processor_interrupt_out = irq;
endmodule
`default_nettype wire

// ===== src/dss_processor.sv
// Processor end: slaved to the bit clock, own framing on transmit
`timescale 1ns/100ps
`default_nettype none
`include "dss_regs.svh"
module dss_processor (
   input wire logic clk, // Processor clock
   input wire logic nrst, // Synchronous reset, active low
   input wire logic bw_start, // Pulse: send a bin width frame
   input wire dss_pkg::dss_word_type bw_word, // Bin width for current slot
   output logic bw_take, // Pulse: bw_word consumed
   output dss_pkg::dss_word_type stats_word, // Last statistics word received
   output logic stats_valid, // Pulse: new statistics word
   output logic irq_edge, // Pulse: interrupt line rose
   dss_if.processor link // Serial link
);
   logic clk_meta, clk_sync, clk_prev;
   logic sy_meta, sy_sync, d_meta, d_sync, irq_meta, irq_sync, irq_prev;
   logic pending, take, in_valid, tx_sync, tx_data;
   dss_pkg::dss_word_type in_word;
   wire logic clk_rise = clk_sync && !clk_prev;
   wire logic clk_fall = !clk_sync && clk_prev;

   // Bit clock comes from the device, never made here
   always_ff @(posedge clk) begin
      if (!nrst) begin
         clk_meta <= 1'b0;
         clk_sync <= 1'b0;
         clk_prev <= 1'b0;
         sy_meta <= 1'b0;
         sy_sync <= 1'b0;
         d_meta <= 1'b0;
         d_sync <= 1'b0;
         irq_meta <= 1'b0;
         irq_sync <= 1'b0;
         irq_prev <= 1'b0;
      end else begin
         clk_meta <= link.serial_bit_clock;
         clk_sync <= clk_meta;
         clk_prev <= clk_sync;
         sy_meta <= link.transmit_frame_sync;
         sy_sync <= sy_meta;
         d_meta <= link.serial_tx_data;
         d_sync <= d_meta;
         irq_meta <= link.processor_interrupt_out;
         irq_sync <= irq_meta;
         irq_prev <= irq_sync;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pending <= 1'b0;
      end else if (bw_start) begin
         pending <= 1'b1;
      end else if (clk_rise) begin
         pending <= 1'b0;
      end
   end

   // Receive framing follows the device sync; transmit sync made locally
   dss_shifter #(.SLOTS_OUT(`DSS_RX_SLOTS), .SLOTS_IN(`DSS_TX_SLOTS)) u_shift (
      .clk(clk),
      .nrst(nrst),
      .launch(clk_rise),
      .sample(clk_fall),
      .start(pending),
      .out_word(bw_word),
      .out_take(take),
      .out_busy(),
      .sync_out(tx_sync),
      .data_out(tx_data),
      .sync_in(sy_sync),
      .data_in(d_sync),
      .in_word(in_word),
      .in_valid(in_valid),
      .in_busy()
   );

   always_ff @(posedge clk) begin
      if (!nrst) begin
         bw_take <= 1'b0;
         stats_word <= 16'h0000;
         stats_valid <= 1'b0;
         irq_edge <= 1'b0;
      end else begin
         bw_take <= take;
         stats_valid <= in_valid;
         irq_edge <= irq_sync && !irq_prev; // Level held long, so edge detect
         if (in_valid) begin
            stats_word <= in_word;
         end
      end
   end

   assign link.receive_frame_sync = tx_sync;
   assign link.serial_rx_data = tx_data;
endmodule
`default_nettype wire

// ===== src/dss_shifter.sv
// One serial word engine: frame sync, shift out and shift in by slot count
`timescale 1ns/100ps
`default_nettype none
`include "dss_regs.svh"
module dss_shifter #(
   parameter int SLOTS_OUT = 52,
   parameter int SLOTS_IN = 84
) (
   input wire logic clk, // System clock
   input wire logic nrst, // Synchronous reset, active low
   input wire logic launch, // Launch strobe, just after a bit clock rise
   input wire logic sample, // Sample strobe, just after a bit clock fall
   input wire logic start, // Begin an outgoing frame
   input wire dss_pkg::dss_word_type out_word, // Word for the current outgoing slot
   output logic out_take, // Pulse: out_word consumed
   output logic out_busy, // Outgoing frame in progress
   output logic sync_out, // Outgoing frame sync
   output logic data_out, // Outgoing serial data
   input wire logic sync_in, // Incoming frame sync, already synchronised
   input wire logic data_in, // Incoming data, already synchronised
   output dss_pkg::dss_word_type in_word, // Last assembled incoming word
   output logic in_valid, // Pulse: in_word new
   output logic in_busy // Incoming frame in progress
);
   // ------------------------------------------------------------
   // Outgoing side
   // ------------------------------------------------------------
   dss_pkg::dss_tx_state_type state;
   dss_pkg::dss_word_type tx_shift;
   logic [3:0] tx_bit;
   logic [7:0] tx_slot;
   wire logic tx_word_end = (tx_bit == `DSS_BIT_LAST);
   wire logic tx_frame_end = tx_word_end && (tx_slot == 8'(SLOTS_OUT - 1));

   always_ff @(posedge clk) begin
      out_take <= 1'b0;
      if (!nrst) begin
         state <= dss_pkg::dss_idle;
         tx_shift <= 16'h0000;
         tx_bit <= 4'h0;
         tx_slot <= 8'h00;
         sync_out <= 1'b0;
         data_out <= 1'b0;
      end else if (launch) begin
         case (state)
            dss_pkg::dss_idle: begin
               sync_out <= 1'b0;
               data_out <= 1'b0;
               if (start) begin
                  sync_out <= 1'b1; // One period ahead of first bit
                  state <= dss_pkg::dss_sync;
               end
            end
            dss_pkg::dss_sync: begin
               sync_out <= 1'b0; // High one period exactly
               data_out <= out_word[15]; // MSB first
               tx_shift <= {out_word[14:0], 1'b0};
               out_take <= 1'b1;
               tx_bit <= 4'h0;
               tx_slot <= 8'h00;
               state <= dss_pkg::dss_data;
            end
            dss_pkg::dss_data: begin
               if (tx_frame_end) begin
                  data_out <= 1'b0;
                  state <= dss_pkg::dss_idle; // Frame of SLOTS_OUT words
               end else if (tx_word_end) begin
                  data_out <= out_word[15];
                  tx_shift <= {out_word[14:0], 1'b0};
                  out_take <= 1'b1;
                  tx_bit <= 4'h0;
                  tx_slot <= tx_slot + 8'h01;
               end else begin
                  data_out <= tx_shift[15];
                  tx_shift <= {tx_shift[14:0], 1'b0};
                  tx_bit <= tx_bit + 4'h1;
               end
            end
            default: state <= dss_pkg::dss_idle;
         endcase
      end
   end

   assign out_busy = (state != dss_pkg::dss_idle);

   // ------------------------------------------------------------
   // Incoming side
   // ------------------------------------------------------------
   logic sync_prev;
   logic armed;
   dss_pkg::dss_word_type rx_shift;
   logic [3:0] rx_bit;
   logic [7:0] rx_slot;
   wire logic sync_rise = sync_in && !sync_prev;

   always_ff @(posedge clk) begin
      in_valid <= 1'b0;
      if (!nrst) begin
         sync_prev <= 1'b0;
         armed <= 1'b0;
         in_busy <= 1'b0;
         rx_shift <= 16'h0000;
         rx_bit <= 4'h0;
         rx_slot <= 8'h00;
         in_word <= 16'h0000;
      end else if (sample) begin
         sync_prev <= sync_in;
         if (in_busy) begin
            rx_shift <= {rx_shift[14:0], data_in}; // MSB arrives first
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == `DSS_BIT_LAST) begin
               in_word <= {rx_shift[14:0], data_in};
               in_valid <= 1'b1;
               rx_slot <= rx_slot + 8'h01;
               if (rx_slot == 8'(SLOTS_IN - 1)) begin
                  in_busy <= 1'b0; // Frame of SLOTS_IN words
               end
            end
         end else if (armed) begin
            armed <= 1'b0;
            in_busy <= 1'b1;
            rx_shift <= {15'h0000, data_in};
            rx_bit <= 4'h1;
            rx_slot <= 8'h00;
         end else if (sync_rise) begin
            armed <= 1'b1; // Frame begins one period after the rise
         end
      end
   end
endmodule
`default_nettype wire
